// *** fte_pkg.sv ***
// Shared constants, types and register map of the flow event and totalizer block.
package fte_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int TICKS_PER_S = 1000 / TICK_MS;
   localparam int SAVE_S = 1;
   localparam int SAVE_TICKS = SAVE_S * TICKS_PER_S;
   localparam int CONFIRM_S = 2;
   localparam int CONFIRM_TICKS = CONFIRM_S * TICKS_PER_S;
   localparam int DONE_S = 2;
   localparam int DONE_TICKS = DONE_S * TICKS_PER_S;
   localparam int FLOW_W = 12;
   localparam int TOT_W = 32;
   localparam logic [11:0] DELAY_MAX_S = 12'he10;
   localparam logic [11:0] START_MAX = 12'h3e8;
   localparam logic [11:0] CUT_MAX = 12'h064;
   localparam logic [11:0] CUT_HYST = 12'h00a;
   localparam logic [15:0] VOLT_ZERO = 16'h0000;
   localparam logic [15:0] LOOP_ZERO = 16'h0190;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [31:0] TOT_RST = 32'h0000_0000;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam int CB_PRIM_EN = 0;
   localparam int CB_SEC_EN = 1;
   localparam int CB_FLOW_AL = 2;
   localparam int CB_TEMP_AL = 3;
   localparam int CB_FLOW_LATCH = 4;
   localparam int CB_TEMP_LATCH = 5;
   localparam int CMD_PRIM = 0;
   localparam int CMD_SEC = 1;
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_CUTOFF = 8'h04;
   localparam logic [7:0] ADR_FLOW_LO = 8'h08;
   localparam logic [7:0] ADR_FLOW_HI = 8'h0c;
   localparam logic [7:0] ADR_TEMP_LO = 8'h10;
   localparam logic [7:0] ADR_TEMP_HI = 8'h14;
   localparam logic [7:0] ADR_FLOW_DLY = 8'h18;
   localparam logic [7:0] ADR_TEMP_DLY = 8'h1c;
   localparam logic [7:0] ADR_PRIM_START = 8'h20;
   localparam logic [7:0] ADR_PRIM_EVENT = 8'h24;
   localparam logic [7:0] ADR_SEC_START = 8'h28;
   localparam logic [7:0] ADR_SEC_EVENT = 8'h2c;
   localparam logic [7:0] ADR_OUT_FUNC = 8'h30;
   localparam logic [7:0] ADR_RESET_CMD = 8'h34;
   localparam logic [7:0] ADR_STATUS = 8'h38;
   localparam logic [7:0] ADR_PRIM_TOTAL = 8'h3c;
   localparam logic [7:0] ADR_SEC_TOTAL = 8'h40;

   typedef enum logic [3:0] {
      FN_OFF, FN_FLOW_LO, FN_FLOW_HI, FN_FLOW_RANGE, FN_PRIM_EV, FN_SEC_EV,
      FN_TEMP_LO, FN_TEMP_HI, FN_TEMP_RANGE, FN_DIAG, FN_MANUAL
   } fte_func_t;
   localparam logic [3:0] FN_LAST = 4'ha;

   typedef enum logic [1:0] {TR_IDLE, TR_WINDOW, TR_DONE} fte_trs_t;

   typedef struct packed {
      logic enable;
      logic [FLOW_W-1:0] start;
      logic [TOT_W-1:0] eventVol;
   } fte_tot_cfg_t;

   typedef struct packed {
      logic [TOT_W-1:0] total;
      logic hit;
      logic window;
      logic done;
   } fte_tot_sts_t;

   typedef struct packed {
      logic [1:0] opt;
      logic secDone;
      logic secWin;
      logic primDone;
      logic primWin;
      logic secEv;
      logic primEv;
      logic cut;
      logic [3:0] alarm;
   } fte_status_t;
endpackage

// *** fte_totalizer.sv ***
// One flow totalizer with start threshold, event compare and two-step reset.
`timescale 1ns/1ps
module fte_totalizer (
   input wire logic mclk,
   input wire logic rst,
   input wire logic tick,
   input wire fte_pkg::fte_tot_cfg_t cfg,
   input wire logic [fte_pkg::FLOW_W-1:0] flowEff,
   input wire logic cutActive,
   input wire logic confirm,
   input wire logic loadValid,
   input wire logic [fte_pkg::TOT_W-1:0] loadData,
   output fte_pkg::fte_tot_sts_t sts
);
   import fte_pkg::*;

   logic [TOT_W-1:0] total;
   logic eventHit;
   fte_trs_t state;
   logic [4:0] cnt;
   logic clearNow;
   logic countOk;

   assign clearNow = (state == TR_WINDOW) && confirm;
   assign countOk = cfg.enable && !cutActive && (flowEff >= cfg.start);

   always_ff @(posedge mclk) begin
      if (rst) begin
         total <= TOT_RST;
      end else if (loadValid) begin
         total <= loadData;
      end else if (clearNow) begin
         total <= TOT_RST;
      end else if (tick && countOk) begin
         total <= total + TOT_W'(flowEff);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         eventHit <= 1'b0;
      end else begin
         eventHit <= (cfg.eventVol != TOT_RST) && (total == cfg.eventVol);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= TR_IDLE;
         cnt <= 5'h00;
      end else begin
         unique case (state)
            TR_IDLE: begin
               cnt <= 5'h00;
               if (confirm) begin
                  state <= TR_WINDOW;
               end
            end
            TR_WINDOW: begin
               if (confirm) begin
                  state <= TR_DONE;
                  cnt <= 5'h00;
               end else if (tick) begin
                  if (cnt == 5'(CONFIRM_TICKS - 1)) begin
                     state <= TR_IDLE;
                  end
                  cnt <= cnt + 5'h01;
               end
            end
            TR_DONE: begin
               if (tick) begin
                  if (cnt == 5'(DONE_TICKS - 1)) begin
                     state <= TR_IDLE;
                  end
                  cnt <= cnt + 5'h01;
               end
            end
         endcase
      end
   end

   assign sts.total = total;
   assign sts.hit = eventHit;
   assign sts.window = (state == TR_WINDOW);
   assign sts.done = (state == TR_DONE);
endmodule

// *** fte_flow_events.sv ***
// Flow meter event logic: alarms, cut-off, two totalizers, optical outputs and register slave.
//
// Function
// - Temperature alarm only after programmed delay
// - Unlatched temperature alarm follows violation only
// - Primary total integrates flow, saved each second
// - Primary total restored from storage at power-up
// - Totalizers count only at or above start
// - Start threshold in 0.1 percent, max 100
// - Volume event when total equals event volume
// - Zero event volume disables the event
// - Totalizer enable, disabled after reset
// - Reset needs second press within two seconds
// - Secondary total volatile, updated every 100 ms
// - Two outputs, each with eleven-way selector
// - Disabled output stays off
// - Flow low, high and range functions
// - Totalizer limit functions from event compare
// - Temperature functions only with probe option
// - Diagnostic function follows any diagnostic event
// - Manual-on stays on until disabled
// - Cut-off 0 to 10 percent, flow zeroed
// - Analog outputs at zero codes during cut-off
// - Cut-off release has 1 percent hysteresis
// - Flow alarm at or beyond its limit
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module fte_flow_events #(
   parameter int TICK_CYCLES = fte_pkg::TICK_CYCLES,
   parameter bit TEMPERATURE_PROBE_OPTION = 1'b1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [fte_pkg::FLOW_W-1:0] flowRate,
   input wire logic signed [15:0] tempReading,
   input wire logic diagActive,
   input wire logic nvLoadValid,
   input wire logic [fte_pkg::TOT_W-1:0] nvLoadData,
   output logic nvSaveStrobe,
   output logic [fte_pkg::TOT_W-1:0] nvSaveData,
   output logic [1:0] optOut,
   output logic [15:0] analogVoltCode,
   output logic [15:0] analogLoopCode
);
   import fte_pkg::*;

   if (TICK_CYCLES < 2) begin : gBadTick
      $error("TICK_CYCLES must be at least 2");
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [11:0] clamp12(input logic [31:0] v, input logic [11:0] lim);
      logic [11:0] r;
      r = (v > {20'h00000, lim}) ? lim : v[11:0];
      return r;
   endfunction

   function automatic logic [15:0] secToTicks(input logic [11:0] s);
      logic [15:0] r;
      r = 16'(s * 16'(TICKS_PER_S));
      return r;
   endfunction

   // Pick the raw event source for one output.
   function automatic logic pickSource(input fte_func_t f, input logic [3:0] al,
                                       input logic fRange, input logic tRange,
                                       input logic pEv, input logic sEv, input logic diag);
      logic r;
      r = 1'b0;
      unique case (f)
         FN_OFF: r = 1'b0;
         FN_FLOW_LO: r = al[0];
         FN_FLOW_HI: r = al[1];
         FN_FLOW_RANGE: r = fRange;
         FN_PRIM_EV: r = pEv;
         FN_SEC_EV: r = sEv;
         FN_TEMP_LO: r = al[2];
         FN_TEMP_HI: r = al[3];
         FN_TEMP_RANGE: r = tRange;
         FN_DIAG: r = diag;
         FN_MANUAL: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   logic [5:0] ctrl;
   logic [11:0] cutoff;
   logic [11:0] flowLo;
   logic [11:0] flowHi;
   logic signed [15:0] tempLo;
   logic signed [15:0] tempHi;
   logic [11:0] flowDly;
   logic [11:0] tempDly;
   fte_tot_cfg_t primCfg;
   fte_tot_cfg_t secCfg;
   fte_func_t func [2];
   fte_func_t funcPrev [2];
   logic cfmPrim;
   logic cfmSec;
   fte_tot_sts_t primSts;
   fte_tot_sts_t secSts;

   logic [31:0] tickCnt;
   logic tick;
   logic [3:0] saveCnt;
   logic cutActive;
   logic [FLOW_W-1:0] flowEff;
   logic [3:0] viol;
   logic [3:0] alarm;
   logic [15:0] dlyCnt [4];
   logic [15:0] dlyLim [4];
   logic flowRange;
   logic tempRange;
   logic [1:0] latched;
   logic [1:0] src;
   logic [1:0] latchable;
   logic access;
   logic doWrite;
   logic [31:0] wr;
   logic [31:0] wrCtrl, wrLo, wrHi;
   fte_status_t status;

   // Bus handshake: the request is held one cycle, then answered.
   assign access = (read || write) && waitrequest;
   assign doWrite = write && !waitrequest;

   always_ff @(posedge mclk) begin
      if (rst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !access;
      end
   end

   // Time base of 100 ms steps.
   always_ff @(posedge mclk) begin
      if (rst) begin
         tickCnt <= 32'h0000_0000;
         tick <= 1'b0;
      end else begin
         tick <= (tickCnt == 32'(TICK_CYCLES - 1));
         if (tickCnt == 32'(TICK_CYCLES - 1)) begin
            tickCnt <= 32'h0000_0000;
         end else begin
            tickCnt <= tickCnt + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         saveCnt <= 4'h0;
         nvSaveStrobe <= 1'b0;
         nvSaveData <= TOT_RST;
      end else begin
         nvSaveStrobe <= 1'b0;
         if (tick) begin
            if (saveCnt == 4'(SAVE_TICKS - 1)) begin
               saveCnt <= 4'h0;
               nvSaveStrobe <= 1'b1;
               nvSaveData <= primSts.total;
            end else begin
               saveCnt <= saveCnt + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cutActive <= 1'b0;
      end else if (flowRate < cutoff) begin
         cutActive <= 1'b1;
      end else if (flowRate >= cutoff + CUT_HYST) begin
         cutActive <= 1'b0;
      end
   end

   assign flowEff = cutActive ? '0 : flowRate;

   always_ff @(posedge mclk) begin
      if (rst) begin
         analogVoltCode <= VOLT_ZERO;
         analogLoopCode <= LOOP_ZERO;
      end else begin
         analogVoltCode <= VOLT_ZERO + 16'(flowEff * 16'h0005);
         analogLoopCode <= LOOP_ZERO + 16'((flowEff * 16'h0008) / 16'h0005);
      end
   end

   // flow at or beyond limit, probe gating
   always_comb begin
      viol[0] = ctrl[CB_FLOW_AL] && (flowEff <= flowLo);
      viol[1] = ctrl[CB_FLOW_AL] && (flowEff >= flowHi);
      viol[2] = TEMPERATURE_PROBE_OPTION && ctrl[CB_TEMP_AL] && (tempReading <= tempLo);
      viol[3] = TEMPERATURE_PROBE_OPTION && ctrl[CB_TEMP_AL] && (tempReading >= tempHi);
   end

   assign dlyLim[0] = secToTicks(flowDly);
   assign dlyLim[1] = secToTicks(flowDly);
   assign dlyLim[2] = secToTicks(tempDly);
   assign dlyLim[3] = secToTicks(tempDly);

   // action delay, restart on recovery, follow level
   always_ff @(posedge mclk) begin
      for (int i = 0; i < 4; i++) begin
         if (rst || !viol[i]) begin
            dlyCnt[i] <= 16'h0000;
            alarm[i] <= 1'b0;
         end else begin
            if (tick && dlyCnt[i] < dlyLim[i]) begin
               dlyCnt[i] <= dlyCnt[i] + 16'h0001;
            end
            alarm[i] <= (dlyCnt[i] >= dlyLim[i]);
         end
      end
   end

   assign flowRange = (flowEff > flowLo) && (flowEff < flowHi);
   assign tempRange = TEMPERATURE_PROBE_OPTION && (tempReading > tempLo) && (tempReading < tempHi);

   fte_totalizer uPrim (
      .mclk(mclk),
      .rst(rst),
      .tick(tick),
      .cfg(primCfg),
      .flowEff(flowEff),
      .cutActive(cutActive),
      .confirm(cfmPrim),
      .loadValid(nvLoadValid),
      .loadData(nvLoadData),
      .sts(primSts)
   );

   fte_totalizer uSec (
      .mclk(mclk),
      .rst(rst),
      .tick(tick),
      .cfg(secCfg),
      .flowEff(flowEff),
      .cutActive(cutActive),
      .confirm(cfmSec),
      .loadValid(1'b0),
      .loadData(TOT_RST),
      .sts(secSts)
   );

   always_comb begin
      for (int o = 0; o < 2; o++) begin
         src[o] = pickSource(func[o], alarm, flowRange, tempRange,
                             primSts.hit, secSts.hit, diagActive);
         latchable[o] = (ctrl[CB_FLOW_LATCH] && (func[o] == FN_FLOW_LO || func[o] == FN_FLOW_HI))
                     || (ctrl[CB_TEMP_LATCH] && (func[o] == FN_TEMP_LO || func[o] == FN_TEMP_HI));
      end
   end

   always_ff @(posedge mclk) begin
      for (int o = 0; o < 2; o++) begin
         funcPrev[o] <= func[o];
         if (rst || !latchable[o] || func[o] != funcPrev[o]) begin
            latched[o] <= 1'b0;
         end else if (src[o]) begin
            latched[o] <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      for (int o = 0; o < 2; o++) begin
         if (rst || func[o] == FN_OFF) begin
            optOut[o] <= 1'b0;
         end else begin
            optOut[o] <= src[o] || latched[o];
         end
      end
   end

   assign wr = merge(32'h0000_0000, writedata, byteenable);
   assign wrCtrl = merge({26'h0, ctrl}, writedata, byteenable);
   assign wrLo = merge({16'h0, tempLo}, writedata, byteenable);
   assign wrHi = merge({16'h0, tempHi}, writedata, byteenable);

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl <= CTRL_RST;
         cutoff <= CFG_RST[11:0];
         flowLo <= CFG_RST[11:0];
         flowHi <= CFG_RST[11:0];
         tempLo <= CFG_RST;
         tempHi <= CFG_RST;
         flowDly <= CFG_RST[11:0];
         tempDly <= CFG_RST[11:0];
         primCfg <= '0;
         secCfg <= '0;
         func[0] <= FN_OFF;
         func[1] <= FN_OFF;
      end else if (doWrite) begin
         unique case (address)
            ADR_CTRL: ctrl <= wrCtrl[5:0];
            ADR_CUTOFF: cutoff <= clamp12(wr, CUT_MAX);
            ADR_FLOW_LO: flowLo <= clamp12(wr, START_MAX);
            ADR_FLOW_HI: flowHi <= clamp12(wr, START_MAX);
            ADR_TEMP_LO: tempLo <= wrLo[15:0];
            ADR_TEMP_HI: tempHi <= wrHi[15:0];
            ADR_FLOW_DLY: flowDly <= clamp12(wr, DELAY_MAX_S);
            ADR_TEMP_DLY: tempDly <= clamp12(wr, DELAY_MAX_S);
            ADR_PRIM_START: primCfg.start <= clamp12(wr, START_MAX);
            ADR_PRIM_EVENT: primCfg.eventVol <= merge(primCfg.eventVol, writedata, byteenable);
            ADR_SEC_START: secCfg.start <= clamp12(wr, START_MAX);
            ADR_SEC_EVENT: secCfg.eventVol <= merge(secCfg.eventVol, writedata, byteenable);
            ADR_OUT_FUNC: begin
               // Codes past the last function are refused so the selector stays legal.
               if (byteenable[0] && writedata[3:0] <= FN_LAST) begin
                  func[0] <= fte_func_t'(writedata[3:0]);
               end
               if (byteenable[0] && writedata[7:4] <= FN_LAST) begin
                  func[1] <= fte_func_t'(writedata[7:4]);
               end
            end
            default: begin
            end
         endcase
         if (address == ADR_CTRL) begin
            primCfg.enable <= wrCtrl[CB_PRIM_EN];
            secCfg.enable <= wrCtrl[CB_SEC_EN];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cfmPrim <= 1'b0;
         cfmSec <= 1'b0;
      end else begin
         cfmPrim <= doWrite && address == ADR_RESET_CMD && byteenable[0] && writedata[CMD_PRIM];
         cfmSec <= doWrite && address == ADR_RESET_CMD && byteenable[0] && writedata[CMD_SEC];
      end
   end

   always_comb begin
      status.opt = optOut;
      status.secDone = secSts.done;
      status.secWin = secSts.window;
      status.primDone = primSts.done;
      status.primWin = primSts.window;
      status.secEv = secSts.hit;
      status.primEv = primSts.hit;
      status.cut = cutActive;
      status.alarm = alarm;
   end

   // Read data is captured in the wait cycle; unmapped words read as zero.
   always_ff @(posedge mclk) begin
      if (rst) begin
         readdata <= 32'h0000_0000;
      end else if (access && read) begin
         unique case (address)
            ADR_CTRL: readdata <= {26'h0, ctrl};
            ADR_CUTOFF: readdata <= {20'h0, cutoff};
            ADR_FLOW_LO: readdata <= {20'h0, flowLo};
            ADR_FLOW_HI: readdata <= {20'h0, flowHi};
            ADR_TEMP_LO: readdata <= {16'h0, tempLo};
            ADR_TEMP_HI: readdata <= {16'h0, tempHi};
            ADR_FLOW_DLY: readdata <= {20'h0, flowDly};
            ADR_TEMP_DLY: readdata <= {20'h0, tempDly};
            ADR_PRIM_START: readdata <= {20'h0, primCfg.start};
            ADR_PRIM_EVENT: readdata <= primCfg.eventVol;
            ADR_SEC_START: readdata <= {20'h0, secCfg.start};
            ADR_SEC_EVENT: readdata <= secCfg.eventVol;
            ADR_OUT_FUNC: readdata <= {24'h0, func[1], func[0]};
            ADR_STATUS: readdata <= {19'h0, status};
            ADR_PRIM_TOTAL: readdata <= primSts.total;
            ADR_SEC_TOTAL: readdata <= secSts.total;
            default: readdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// *** fte_totalizer_fix_note_placeholder.sv ***
// Intentionally empty compilation unit kept for ordering.

// *** fte_nv_store.sv ***
// Non-volatile store model that keeps the last saved primary total and replays it at power-up.
`timescale 1ns/1ps
module fte_nv_store (
   input wire logic mclk,
   input wire logic saveStrobe,
   input wire logic [fte_pkg::TOT_W-1:0] saveData,
   input wire logic restore,
   output logic loadValid,
   output logic [fte_pkg::TOT_W-1:0] loadData
);
   import fte_pkg::*;
   logic [TOT_W-1:0] kept = 32'h0;
   initial loadValid = 1'b0;
   initial loadData = 32'h5a5a_a5a5;
   always @(posedge mclk) begin
      if (saveStrobe) begin
         kept <= saveData;
      end
   end
   // Replays the saved total.
   // The data lines toggle while idle, so stale data can never pass for a restore.
   always @(posedge mclk) begin
      loadValid <= restore;
      loadData <= restore ? kept : ~loadData;
   end
endmodule

// *** fte_flow_events_chk.sv ***
// Bus, save-pulse and analog-code assertions for the flow event block.
`timescale 1ns/1ps
module fte_flow_events_chk #(
   parameter int TICK_CYCLES = 20
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [fte_pkg::FLOW_W-1:0] flowRate,
   input wire logic nvSaveStrobe,
   input wire logic [1:0] optOut,
   input wire logic [15:0] analogVoltCode,
   input wire logic [15:0] analogLoopCode
);
   import fte_pkg::*;
   int gap;
   logic seen;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   always_ff @(posedge mclk) begin
      if (rst || nvSaveStrobe) gap <= 0;
      else gap <= gap + 1;
   end
   always_ff @(posedge mclk) begin
      if (rst) seen <= 1'b0;
      else if (nvSaveStrobe) seen <= 1'b1;
   end
   sequence reqSeen; (read || write) && waitrequest; endsequence
   sequence ackOnce; !waitrequest ##1 waitrequest; endsequence
   bus_answer_a: assert property (reqSeen |=> ackOnce)
      else $error("bus answer late or long");
   bus_idle_a: assert property (!read && !write |=> waitrequest)
      else $error("ack without request");
   read_hold_a: assert property (waitrequest |-> $stable(readdata))
      else $error("read data moved");
   save_pulse_a: assert property (nvSaveStrobe |=> !nvSaveStrobe)
      else $error("save pulse too long");
   save_period_a: assert property (nvSaveStrobe && seen |-> gap == SAVE_TICKS * TICK_CYCLES - 1)
      else $error("save period wrong");
   reset_quiet_a: assert property ($fell(rst) |-> optOut == 2'b00 && waitrequest && !nvSaveStrobe)
      else $error("outputs active after reset");
   zero_codes_a: assert property (analogVoltCode == VOLT_ZERO |-> analogLoopCode == LOOP_ZERO)
      else $error("loop code not at zero flow");
   volt_scale_a: assert property (!$past(rst) && analogVoltCode != VOLT_ZERO
      |-> analogVoltCode == 16'($past(flowRate)) * 16'h0005)
      else $error("voltage code wrong");
   loop_scale_a: assert property (!$past(rst) && analogVoltCode != VOLT_ZERO
      |-> analogLoopCode == LOOP_ZERO + 16'($past(flowRate)) * 16'h0008 / 16'h0005)
      else $error("loop code wrong");
endmodule
bind fte_flow_events fte_flow_events_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.mclk(mclk), .rst(rst), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest), .flowRate(flowRate),
   .nvSaveStrobe(nvSaveStrobe), .optOut(optOut), .analogVoltCode(analogVoltCode), .analogLoopCode(analogLoopCode));

// *** fte_flow_events_bench.sv ***
// Self-checking bench for the flow event block with a non-volatile store partner.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errorCnt++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module fte_flow_events_bench;
   import fte_pkg::*;
   localparam logic [31:0] ALL = 32'hffff_ffff;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [FLOW_W-1:0] flowRate = 12'h000;
   logic signed [15:0] tempReading = 16'sh0032;
   logic diagActive = 1'b0;
   logic restore = 1'b0;
   logic [31:0] readdata, v, t;
   logic waitrequest, nvLoadValid, nvSaveStrobe;
   logic [TOT_W-1:0] nvLoadData, nvSaveData;
   logic [1:0] optOut;
   logic [15:0] voltCode, loopCode;
   int errorCnt = 0;
   int checked = 0;
   always #20 mclk = ~mclk;
   fte_flow_events #(.TICK_CYCLES(20)) uut (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest), .flowRate(flowRate),
      .tempReading(tempReading), .diagActive(diagActive), .nvLoadValid(nvLoadValid), .nvLoadData(nvLoadData),
      .nvSaveStrobe(nvSaveStrobe), .nvSaveData(nvSaveData), .optOut(optOut), .analogVoltCode(voltCode),
      .analogLoopCode(loopCode));
   fte_nv_store nv (.mclk(mclk), .saveStrobe(nvSaveStrobe), .saveData(nvSaveData), .restore(restore),
      .loadValid(nvLoadValid), .loadData(nvLoadData));
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (waitrequest === 1'b0) break;
      end
      if (n == 50) errorCnt++;
      v = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(v & m, e)
   endtask
   task automatic wrapUp;
      $display("checked %0d mismatches %0d", checked, errorCnt);
      if (errorCnt == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      $display("BAD %0t watchdog expired", $time);
      errorCnt++;
      wrapUp;
   end
   initial begin
      cyc(8);
      rst <= 1'b0;
      rdChk(ADR_CTRL, ALL, 32'h0);
      rdChk(ADR_PRIM_EVENT, ALL, 32'h0);
      rdChk(8'hfc, ALL, 32'h0);
      `CHK(optOut, 2'b00)
      $display("test defaults done");
      bus(1'b1, ADR_PRIM_START, 32'h7d0);
      rdChk(ADR_PRIM_START, ALL, 32'(START_MAX));
      bus(1'b1, ADR_PRIM_START, 32'h32);
      flowRate <= 12'h064;
      bus(1'b1, ADR_CTRL, 32'h3);
      cyc(100);
      bus(1'b0, ADR_PRIM_TOTAL, 32'h0);
      `CHK({v % 32'h64, v != 32'h0}, {32'h0, 1'b1})
      bus(1'b0, ADR_SEC_TOTAL, 32'h0);
      `CHK({v % 32'h64, v != 32'h0}, {32'h0, 1'b1})
      flowRate <= 12'h028;
      cyc(2);
      bus(1'b0, ADR_PRIM_TOTAL, 32'h0);
      t = v;
      cyc(60);
      rdChk(ADR_PRIM_TOTAL, ALL, t);
      flowRate <= 12'h032;
      cyc(60);
      bus(1'b0, ADR_PRIM_TOTAL, 32'h0);
      `CHK(v != t, 1'b1)
      $display("test accumulate done");
      bus(1'b1, ADR_CTRL, 32'h0);
      bus(1'b0, ADR_PRIM_TOTAL, 32'h0);
      t = v;
      cyc(60);
      rdChk(ADR_PRIM_TOTAL, ALL, t);
      bus(1'b1, ADR_PRIM_EVENT, t);
      rdChk(ADR_STATUS, 32'h20, 32'h20);
      bus(1'b1, ADR_OUT_FUNC, 32'ha4);
      cyc(5);
      `CHK(optOut, 2'b11)
      bus(1'b1, ADR_PRIM_EVENT, 32'h0);
      cyc(5);
      `CHK(optOut, 2'b10)
      $display("test event done");
      // A lone press must expire, so the late second press only opens a new window.
      bus(1'b1, ADR_RESET_CMD, 32'h1);
      rdChk(ADR_STATUS, 32'h80, 32'h80);
      cyc(420);
      bus(1'b1, ADR_RESET_CMD, 32'h1);
      rdChk(ADR_PRIM_TOTAL, ALL, t);
      bus(1'b1, ADR_RESET_CMD, 32'h1);
      rdChk(ADR_PRIM_TOTAL, ALL, 32'h0);
      rdChk(ADR_STATUS, 32'h180, 32'h100);
      $display("test clear done");
      bus(1'b1, ADR_CUTOFF, 32'hc8);
      rdChk(ADR_CUTOFF, ALL, 32'(CUT_MAX));
      bus(1'b1, ADR_CUTOFF, 32'h14);
      bus(1'b1, ADR_CTRL, 32'h3);
      flowRate <= 12'h00f;
      cyc(5);
      `CHK({voltCode, loopCode}, {VOLT_ZERO, LOOP_ZERO})
      bus(1'b0, ADR_SEC_TOTAL, 32'h0);
      t = v;
      cyc(60);
      rdChk(ADR_SEC_TOTAL, ALL, t);
      flowRate <= 12'h01d;
      cyc(5);
      rdChk(ADR_STATUS, 32'h10, 32'h10);
      flowRate <= 12'h01e;
      cyc(5);
      `CHK(voltCode, 16'h0096)
      $display("test cutoff done");
      bus(1'b1, ADR_FLOW_LO, 32'h64);
      bus(1'b1, ADR_FLOW_HI, 32'h1f4);
      bus(1'b1, ADR_CTRL, 32'h7);
      bus(1'b1, ADR_OUT_FUNC, 32'h93);
      flowRate <= 12'h12c;
      diagActive <= 1'b1;
      cyc(5);
      `CHK(optOut, 2'b11)
      flowRate <= 12'h1f4;
      diagActive <= 1'b0;
      cyc(5);
      `CHK(optOut, 2'b00)
      rdChk(ADR_STATUS, 32'h3, 32'h2);
      bus(1'b1, ADR_OUT_FUNC, 32'h01);
      flowRate <= 12'h064;
      cyc(5);
      `CHK(optOut, 2'b01)
      bus(1'b1, ADR_OUT_FUNC, 32'h0);
      cyc(5);
      `CHK(optOut, 2'b00)
      $display("test functions done");
      bus(1'b1, ADR_TEMP_HI, 32'h64);
      bus(1'b1, ADR_TEMP_DLY, 32'h1);
      bus(1'b1, ADR_CTRL, 32'hb);
      bus(1'b1, ADR_OUT_FUNC, 32'h07);
      tempReading <= 16'sh0096;
      cyc(150);
      `CHK(optOut, 2'b00)
      cyc(100);
      `CHK(optOut, 2'b01)
      tempReading <= 16'sh0032;
      cyc(5);
      `CHK(optOut, 2'b00)
      tempReading <= 16'sh0096;
      cyc(150);
      tempReading <= 16'sh0032;
      cyc(30);
      tempReading <= 16'sh0096;
      cyc(150);
      `CHK(optOut, 2'b00)
      bus(1'b1, ADR_CTRL, 32'h2b);
      cyc(100);
      tempReading <= 16'sh0032;
      cyc(5);
      `CHK(optOut, 2'b01)
      bus(1'b1, ADR_OUT_FUNC, 32'h06);
      cyc(5);
      `CHK(optOut, 2'b00)
      $display("test temperature done");
      bus(1'b1, ADR_CTRL, 32'h0);
      bus(1'b0, ADR_PRIM_TOTAL, 32'h0);
      t = v;
      cyc(210);
      rst <= 1'b1;
      cyc(8);
      rst <= 1'b0;
      restore <= 1'b1;
      cyc(1);
      restore <= 1'b0;
      cyc(3);
      rdChk(ADR_PRIM_TOTAL, ALL, t);
      rdChk(ADR_SEC_TOTAL, ALL, 32'h0);
      rdChk(ADR_CTRL, ALL, 32'h0);
      $display("test power cycle done");
      wrapUp;
   end
endmodule
